//--- dv/sps_core_model.sv
`timescale 1ns/1ps
// core side of the flag stack: keeps what entry pushed, hands it back at return
module sps_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       flags_push_valid,
  input  wire logic [7:0] flags_push_data,
  input  wire logic       irq_return,
  output logic      [7:0] irq_restore_flags
);
  logic [7:0] stack_mem [0:3];
  logic [1:0] depth;

  // push on entry, pop on return; three levels is enough for nested tests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth <= 2'h0;
    end else if (flags_push_valid) begin
      stack_mem[depth] <= flags_push_data;
      depth            <= depth + 2'h1;
    end else if (irq_return && depth != 2'h0) begin
      depth <= depth - 2'h1;
    end
  end

  // empty stack shows a junk pattern so a stray pop is not masked
  assign irq_restore_flags = (depth == 2'h0) ? 8'h5a : stack_mem[depth - 2'h1];
endmodule

//--- dv/sram_page_select_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module sram_page_select_test;
  import sps_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bnd, acc_v;
  logic        sp_inc, sp_dec, irq_enter, irq_return, awready, wready, bvalid, arready, rvalid;
  logic        sram_valid, flags_push_valid;
  logic [7:0]  awaddr, araddr, acc_addr, irq_rf, flags_push_data, flags, sp, fm;
  logic [31:0] wdata, rdata, rd, w, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lm;
  logic [10:0] sram_addr, ea;
  logic [2:0]  pp [5];
  logic [2:0]  lp [5];
  logic [10:0] aq [$];
  logic [7:0]  pq [$];
  sps_kind_t   acc_kind;
  int          bad_count, comparisons, cyc;

  sps_top sps_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_boundary(bnd),
    .access_valid(acc_v), .access_kind(acc_kind), .access_addr(acc_addr), .sp_inc(sp_inc),
    .sp_dec(sp_dec), .irq_enter(irq_enter), .irq_return(irq_return), .irq_restore_flags(irq_rf),
    .sram_valid(sram_valid), .sram_addr(sram_addr), .flags_push_valid(flags_push_valid),
    .flags_push_data(flags_push_data), .flags(flags));

  sps_core_model sps_core_model_i (.aclk(aclk), .aresetn(aresetn), .flags_push_valid(flags_push_valid),
    .flags_push_data(flags_push_data), .irq_return(irq_return), .irq_restore_flags(irq_rf));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    `CHK("rresp", er, rresp)
  endtask

  // copies latched by the design at the boundary are mirrored here
  task automatic boundary();
    lp = pp;
    lm = fm[7:6];
    @(posedge aclk);
    bnd <= 1'b1;
    @(posedge aclk);
    bnd <= 1'b0;
  endtask

  task automatic acc(input sps_kind_t k, input logic [7:0] a);
    logic [2:0] p;
    case (k)
      KIND_STACK:   p = lp[1];
      KIND_INDEXED: p = (lm == MODE_PAGE0) ? 3'h0 : (lm == MODE_IDX) ? lp[2] : lp[1];
      KIND_MOVE_RD: p = lp[3];
      KIND_MOVE_WR: p = lp[4];
      default:      p = lm[1] ? lp[0] : 3'h0;
    endcase
    aq.push_back({p, (k == KIND_STACK) ? sp : a});
    @(posedge aclk);
    acc_v    <= 1'b1;
    acc_kind <= k;
    acc_addr <= a;
    @(posedge aclk);
    acc_v <= 1'b0;
  endtask

  task automatic step(input logic up);
    @(posedge aclk);
    sp_inc <= up;
    sp_dec <= !up;
    @(posedge aclk);
    sp_inc <= 1'b0;
    sp_dec <= 1'b0;
    sp = up ? sp + 8'h01 : sp - 8'h01;
  endtask

  task automatic pulse_irq(input logic ret);
    @(posedge aclk);
    irq_enter  <= !ret;
    irq_return <= ret;
    @(posedge aclk);
    irq_enter  <= 1'b0;
    irq_return <= 1'b0;
    @(posedge aclk);
  endtask

  // result watcher: every sram strobe and flag push consumes the oldest note
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
    if (sram_valid === 1'b1) begin
      ea = (aq.size() != 0) ? aq.pop_front() : 'x;
      `CHK("sram_addr", ea, sram_addr)
    end
    if (flags_push_valid === 1'b1) begin
      ea[7:0] = (pq.size() != 0) ? pq.pop_front() : 'x;
      `CHK("flags_push_data", ea[7:0], flags_push_data)
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bnd, acc_v} = '0;
    {sp_inc, sp_dec, irq_enter, irq_return, awaddr, araddr, acc_addr, wdata} = '0;
    wstrb    = 4'h1;
    acc_kind = KIND_NORMAL;
    seed     = 32'd99;
    pp       = '{default: 3'h0};
    fm       = 8'h00;
    sp       = 8'h00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      axr(8'(4 * i), RESP_OKAY);
      `CHK("reset value", 32'h0, rd)
    end
    axr(8'h1c, RESP_SLVERR);
    axw(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
    // lane 0 strobe low: write answers okay but changes nothing
    wstrb <= 4'h0;
    axw(OFS_CURRENT, 32'h0000_0007, RESP_OKAY);
    wstrb <= 4'h1;
    axr(OFS_CURRENT, RESP_OKAY);
    `CHK("current_page_pointer", 32'h0000_0000, rd)
    // every page mode against every access kind, fresh pointers each pass except the stack page pointer, written in the first pass only
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 5; i++) begin
        w = xs();
        if (i == 1 && m > 0) continue;
        pp[i] = w[2:0];
        axw(8'(4 * i), w, RESP_OKAY);
      end
      axr(OFS_CURRENT, RESP_OKAY);
      `CHK("current_page_pointer", {29'h0, pp[0]}, rd)
      fm = {2'(m), 6'h00};
      axw(OFS_FLAGS, {24'h0, fm}, RESP_OKAY);
      boundary();
      for (int k = 0; k < 6; k++) begin
        w = xs();
        acc(sps_kind_t'(k), w[7:0]);
      end
      acc(KIND_NORMAL, 8'hff);
    end
    // stack wraps inside its page in both directions
    step(1'b0);
    acc(KIND_STACK, 8'h00);
    axr(OFS_STATUS, RESP_OKAY);
    `CHK("stack pointer", 8'hff, rd[7:0])
    step(1'b1);
    acc(KIND_STACK, 8'h00);
    // a pointer write is not seen until the next instruction
    pp[0] = lp[0] + 3'h1;
    axw(OFS_CURRENT, {29'h0, pp[0]}, RESP_OKAY);
    acc(KIND_NORMAL, 8'h42);
    boundary();
    acc(KIND_NORMAL, 8'h43);
    // interrupt entry pushes then clears; return restores flags only
    pq.push_back(fm);
    pulse_irq(1'b0);
    `CHK("flags", FLAGS_IRQ, flags)
    fm = 8'h00;
    boundary();
    acc(KIND_NORMAL, 8'h10);
    acc(KIND_INDEXED, 8'h11);
    acc(KIND_MOVE_WR, 8'h12);
    acc(KIND_STACK, 8'h13);
    pp[0] = pp[0] + 3'h2;
    axw(OFS_CURRENT, {29'h0, pp[0]}, RESP_OKAY);
    pulse_irq(1'b1);
    fm = 8'hc0;
    `CHK("flags", fm, flags)
    axr(OFS_CURRENT, RESP_OKAY);
    `CHK("current_page_pointer", {29'h0, pp[0]}, rd)
    boundary();
    acc(KIND_NORMAL, 8'h20);
    // second reset in mid-run clears the flag register again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_FLAGS, RESP_OKAY);
    `CHK("flags after reset", 32'h0, rd)
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule

//--- logic/sps_page_mux.sv
`timescale 1ns/1ps
module sps_page_mux (
  input  sps_pkg::sps_kind_t              kind,
  input  wire logic [1:0]                 mode,
  input  wire logic [sps_pkg::PAGE_W-1:0] current_page_pointer,
  input  wire logic [sps_pkg::PAGE_W-1:0] stack_page_pointer,
  input  wire logic [sps_pkg::PAGE_W-1:0] index_page_pointer,
  input  wire logic [sps_pkg::PAGE_W-1:0] move_read_page_pointer,
  input  wire logic [sps_pkg::PAGE_W-1:0] move_write_page_pointer,
  output logic      [sps_pkg::PAGE_W-1:0] page
);
  import sps_pkg::*;

  // page choice per access kind
  always_comb begin
    page = PAGE_RST;
    unique case (kind)
      KIND_NORMAL, KIND_MOVE_PTR: page = mode[1] ? current_page_pointer : PAGE_RST;
      KIND_STACK:   page = stack_page_pointer;
      KIND_INDEXED: begin
        unique case (mode)
          MODE_PAGE0:        page = PAGE_RST;
          MODE_ISR, MODE_STK: page = stack_page_pointer;
          MODE_IDX:          page = index_page_pointer;
        endcase
      end
      KIND_MOVE_RD: page = move_read_page_pointer;
      KIND_MOVE_WR: page = move_write_page_pointer;
      default:      page = PAGE_RST;                                // illegal kind codes
    endcase
  end
endmodule

//--- logic/sps_pkg.sv
package sps_pkg;
  // sram geometry
  localparam int PAGE_W  = 3;
  localparam int ADDR_W  = 8;
  localparam int SRAM_W  = PAGE_W + ADDR_W;
  localparam int PAGE_BYTES = 256;

  // register byte offsets on the register bus
  localparam logic [7:0] OFS_CURRENT = 8'h00;
  localparam logic [7:0] OFS_STACK   = 8'h04;
  localparam logic [7:0] OFS_INDEX   = 8'h08;
  localparam logic [7:0] OFS_MOVE_RD = 8'h0C;
  localparam logic [7:0] OFS_MOVE_WR = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;

  // field positions and reset values
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int STAT_SP_LO   = 0;
  localparam int STAT_MODE_LO = 8;
  localparam logic [PAGE_W-1:0] PAGE_RST  = 3'h0;
  localparam logic [7:0]        FLAGS_RST = 8'h00;
  localparam logic [7:0]        FLAGS_IRQ = 8'h00;
  localparam logic [ADDR_W-1:0] SP_RST    = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // page-mode encodings
  localparam logic [1:0] MODE_PAGE0 = 2'b00;
  localparam logic [1:0] MODE_ISR   = 2'b01;
  localparam logic [1:0] MODE_IDX   = 2'b10;
  localparam logic [1:0] MODE_STK   = 2'b11;

  // kind of memory access the core is making
  typedef enum logic [2:0] {
    KIND_NORMAL   = 3'b000,
    KIND_STACK    = 3'b001,
    KIND_INDEXED  = 3'b010,
    KIND_MOVE_PTR = 3'b011,
    KIND_MOVE_RD  = 3'b100,
    KIND_MOVE_WR  = 3'b101
  } sps_kind_t;
endpackage

//--- logic/sps_top.sv
`timescale 1ns/1ps
// Operation
// - each 8-bit address gets a 3-bit page, selecting one of eight 256-byte pages
// - reset clears all page pointers and the page-mode bits
// - page mode off sends normal, move pointer and 00b indexed accesses to page 0
// - page mode on uses current page, except stack, indexed and move data accesses
// - stack accesses use the low three stack page pointer bits always
// - after a call or other stack access, paging returns to prior mode
// - stack pointer wraps 00h/FFh within its page
// - interrupt entry forces the flag register to 00h
// - flags are pushed first, then cleared, on interrupt entry
// - interrupt return restores the saved flag register
// - page pointers are never saved or restored around interrupts
// - move pointer read and write-back use current page, data uses move page
// - move load uses move-read pointer, move store uses move-write pointer
// - move data pages apply whatever the page-mode bits are
// - only non-stack, non-move-data, non-indexed accesses follow current page
// - upper mode bit 0 forces page 0, 1 selects current page pointer
// - indexed: 00b page 0, 01b/11b stack page, 10b index page
// - current page pointer is read/write, low three bits, reset zero
module sps_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       instr_boundary,
  input  wire logic                       access_valid,
  input  sps_pkg::sps_kind_t              access_kind,
  input  wire logic [sps_pkg::ADDR_W-1:0] access_addr,
  input  wire logic                       sp_inc,
  input  wire logic                       sp_dec,
  input  wire logic                       irq_enter,
  input  wire logic                       irq_return,
  input  wire logic [7:0]                 irq_restore_flags,
  output logic                            sram_valid,
  output logic [sps_pkg::SRAM_W-1:0]      sram_addr,
  output logic                            flags_push_valid,
  output logic [7:0]                      flags_push_data,
  output logic [7:0]                      flags
);
  import sps_pkg::*;

  // software-visible pointers and their per-instruction copies
  logic [PAGE_W-1:0] current_page_pointer, stack_page_pointer, index_page_pointer;
  logic [PAGE_W-1:0] move_read_page_pointer, move_write_page_pointer;
  logic [PAGE_W-1:0] act_cur, act_stk, act_idx, act_mvr, act_mvw;
  logic [7:0]        act_flags;
  logic [ADDR_W-1:0] stack_ptr;
  logic [PAGE_W-1:0] sel_page;
  logic [ADDR_W-1:0] eff_addr;

  // write channel state
  logic              aw_held, w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CURRENT) || (a == OFS_STACK) || (a == OFS_INDEX) ||
                (a == OFS_MOVE_RD) || (a == OFS_MOVE_WR) || (a == OFS_FLAGS) ||
                (a == OFS_STATUS);
  endfunction

  function automatic logic [31:0] pad_page(input logic [PAGE_W-1:0] p);
    pad_page = {29'h0000_0000, p};
  endfunction

  // either channel may arrive first; each is held until its partner shows up
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response; read-only status and holes answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (is_mapped(aw_addr) && aw_addr != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // page pointers: only byte lane 0 carries data, upper bits are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_page_pointer    <= PAGE_RST;
      stack_page_pointer      <= PAGE_RST;
      index_page_pointer      <= PAGE_RST;
      move_read_page_pointer  <= PAGE_RST;
      move_write_page_pointer <= PAGE_RST;
    end else if (do_write && w_strb[0]) begin
      // interrupts never touch these, so isr writes persist
      if (aw_addr == OFS_CURRENT) current_page_pointer <= w_data[PAGE_W-1:0];
      if (aw_addr == OFS_STACK)   stack_page_pointer <= w_data[PAGE_W-1:0];
      if (aw_addr == OFS_INDEX)   index_page_pointer <= w_data[PAGE_W-1:0];
      if (aw_addr == OFS_MOVE_RD) move_read_page_pointer <= w_data[PAGE_W-1:0];
      if (aw_addr == OFS_MOVE_WR) move_write_page_pointer <= w_data[PAGE_W-1:0];
    end
  end

  // flag register: return beats entry beats a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= FLAGS_RST;
    end else if (irq_return) begin
      flags <= irq_restore_flags;
    end else if (irq_enter) begin
      flags <= FLAGS_IRQ;
    end else if (do_write && w_strb[0] && aw_addr == OFS_FLAGS) begin
      flags <= w_data[7:0];
    end
  end

  // old flags leave on the push port in the same edge that clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_push_valid <= 1'b0;
      flags_push_data  <= FLAGS_RST;
    end else begin
      flags_push_valid <= irq_enter && !irq_return;
      if (irq_enter && !irq_return) begin
        flags_push_data <= flags;
      end
    end
  end

  // copies seen by accesses change only between instructions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_cur   <= PAGE_RST;
      act_stk   <= PAGE_RST;
      act_idx   <= PAGE_RST;
      act_mvr   <= PAGE_RST;
      act_mvw   <= PAGE_RST;
      act_flags <= FLAGS_RST;
    end else if (instr_boundary) begin
      act_cur   <= current_page_pointer;
      act_stk   <= stack_page_pointer;
      act_idx   <= index_page_pointer;
      act_mvr   <= move_read_page_pointer;
      act_mvw   <= move_write_page_pointer;
      act_flags <= flags;
    end
  end

  // stack pointer wraps inside its page; stack page comes from the software-written stack page pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_ptr <= SP_RST;
    end else if (sp_inc && !sp_dec) begin
      stack_ptr <= stack_ptr + 8'h01;
    end else if (sp_dec && !sp_inc) begin
      stack_ptr <= stack_ptr - 8'h01;
    end
  end

  sps_page_mux sps_page_mux_i (
    .kind                    (access_kind),
    .mode                    (act_flags[MODE_HI:MODE_LO]),
    .current_page_pointer    (act_cur),
    .stack_page_pointer      (act_stk),
    .index_page_pointer      (act_idx),
    .move_read_page_pointer  (act_mvr),
    .move_write_page_pointer (act_mvw),
    .page                    (sel_page)
  );

  // stack accesses use the block's own pointer, not the core's address
  assign eff_addr = (access_kind == KIND_STACK) ? stack_ptr : access_addr;

  // page is chosen per access, so a stack access leaves no mode behind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sram_valid <= 1'b0;
      sram_addr  <= {SRAM_W{1'b0}};
    end else begin
      sram_valid <= access_valid;
      if (access_valid) begin
        sram_addr <= {sel_page, eff_addr};
      end
    end
  end

  // reads answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CURRENT: s_axi_rdata <= pad_page(current_page_pointer);
        OFS_STACK:   s_axi_rdata <= pad_page(stack_page_pointer);
        OFS_INDEX:   s_axi_rdata <= pad_page(index_page_pointer);
        OFS_MOVE_RD: s_axi_rdata <= pad_page(move_read_page_pointer);
        OFS_MOVE_WR: s_axi_rdata <= pad_page(move_write_page_pointer);
        OFS_FLAGS:   s_axi_rdata <= {24'h00_0000, flags};
        OFS_STATUS:  s_axi_rdata <= {22'h00_0000, act_flags[MODE_HI:MODE_LO], stack_ptr};
        default:     s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on what this block drives
  sequence s_enter;
    irq_enter && !irq_return;
  endsequence

  sequence s_pushed_then_clear;
    flags_push_valid && flags == FLAGS_IRQ;
  endsequence

  property p_reset_clear;
    @(posedge aclk) !aresetn
      |=> (current_page_pointer == PAGE_RST && flags == FLAGS_RST && stack_page_pointer == PAGE_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("pointers not clear after reset");

  property p_enter_push;
    @(posedge aclk) disable iff (!aresetn)
      s_enter |=> s_pushed_then_clear ##0 (flags_push_data == $past(flags));
  endproperty
  a_enter_push: assert property (p_enter_push) else $error("flags not pushed then cleared");

  property p_return_restore;
    @(posedge aclk) disable iff (!aresetn)
      irq_return |=> flags == $past(irq_restore_flags);
  endproperty
  a_return_restore: assert property (p_return_restore) else $error("flags not restored on return");

  property p_irq_keeps_ptr;
    @(posedge aclk) disable iff (!aresetn)
      (irq_enter || irq_return) && !do_write
        |=> $stable(current_page_pointer) && $stable(stack_page_pointer) && $stable(index_page_pointer);
  endproperty
  a_irq_keeps_ptr: assert property (p_irq_keeps_ptr) else $error("pointer changed by interrupt");

  property p_stack_page;
    @(posedge aclk) disable iff (!aresetn)
      access_valid && access_kind == KIND_STACK |=> sram_addr == {$past(act_stk), $past(stack_ptr)};
  endproperty
  a_stack_page: assert property (p_stack_page) else $error("stack access off stack page");

  property p_normal_page0;
    @(posedge aclk) disable iff (!aresetn)
      access_valid && access_kind == KIND_NORMAL && !act_flags[MODE_HI]
        |=> sram_addr[SRAM_W-1:ADDR_W] == PAGE_RST;
  endproperty
  a_normal_page0: assert property (p_normal_page0) else $error("normal access not on page 0");

  property p_normal_cur;
    @(posedge aclk) disable iff (!aresetn)
      access_valid && access_kind == KIND_NORMAL && act_flags[MODE_HI]
        |=> sram_addr == {$past(act_cur), $past(access_addr)};
  endproperty
  a_normal_cur: assert property (p_normal_cur) else $error("normal access not on current page");

  property p_move_rd;
    @(posedge aclk) disable iff (!aresetn)
      access_valid && access_kind == KIND_MOVE_RD |=> sram_addr[SRAM_W-1:ADDR_W] == $past(act_mvr);
  endproperty
  a_move_rd: assert property (p_move_rd) else $error("move load on wrong page");

  property p_index_mode10;
    @(posedge aclk) disable iff (!aresetn)
      access_valid && access_kind == KIND_INDEXED && act_flags[MODE_HI:MODE_LO] == MODE_IDX
        |=> sram_addr[SRAM_W-1:ADDR_W] == $past(act_idx);
  endproperty
  a_index_mode10: assert property (p_index_mode10) else $error("indexed access not on index page");

  property p_sp_wrap;
    @(posedge aclk) disable iff (!aresetn)
      sp_dec && !sp_inc && stack_ptr == 8'h00 |=> stack_ptr == 8'hFF;
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("stack pointer did not wrap");

  property p_hold_until_boundary;
    @(posedge aclk) disable iff (!aresetn)
      !instr_boundary |=> $stable(act_cur) && $stable(act_flags);
  endproperty
  a_hold_until_boundary: assert property (p_hold_until_boundary) else $error("copy changed mid-instruction");
endmodule
